// file: rtl/ccp_periph_port.v
// How it works
// - outstanding reads and writes each capped by a limit never above 128
// - cluster capacity is slice write buffers times shared cache slices
// - port accepts at most the smaller of 128 or cluster capacity
// - one exclusive sequence in flight per hardware thread
// - 12-bit transaction ids from one pool shared by reads and writes
// - an id still outstanding is never handed out again
// - originating agent travels in a five-bit logical source id field
// - source and target node ids are 11 bits wide
// - request addresses are 52 bits wide
// - data channel at most 256 bits; only poison flag carried here
// - atomics issued only while the atomic forward strap is high
// - poison carried only when error protection built in and enabled
// - persist clean gives separated request only with persist strap; plain never
// - tlb and icache maintenance become DVMOp only when straps allow
// - SC data accepted; deallocating read-once types never issued
// - load and fetch linefills issue ReadNotSharedDirty
// - store linefills issue ReadUnique
// - store to shared line issues MakeReadUnique, Excl when exclusive
// - speculative store ReadPreferUnique; load exclusive same with Excl
// - full-line store miss issues MakeUnique
// - line zeroing issues WriteUniqueZero or WriteNoSnpZero by shareability
// - non-allocating partial acp unique writes forwarded as WriteUniquePtl
`timescale 1ns/1ns
`include "ccp_defs.vh"
module ccp_periph_port (
	input  wire                       pclk,
	input  wire                       presetn,
	input  wire                       ce,
	input  wire                       psel,
	input  wire                       penable,
	input  wire                       pwrite,
	input  wire [11:0]                paddr,
	input  wire [31:0]                pwdata,
	output reg  [31:0]                prdata,
	output reg                        pready,
	output reg                        pslverr,
	input  wire                       op_valid,
	output reg                        op_ready,
	input  wire [3:0]                 op_kind,
	input  wire [1:0]                 op_aux,
	input  wire                       op_shareable,
	input  wire                       op_excl,
	input  wire [`CCP_ADDR_W-1:0]     op_addr,
	input  wire [`CCP_SRC_W-1:0]      op_source_id,
	output reg                        op_done,
	output reg  [1:0]                 op_status,
	input  wire                       atomic_forward_strap,
	input  wire                       persist_forward_strap,
	input  wire                       tlb_inval_inner_forward,
	input  wire                       tlb_inval_outer_forward,
	input  wire                       icache_inval_forward,
	output reg                        txreq_valid,
	input  wire                       txreq_ready,
	output reg  [6:0]                 txreq_opcode,
	output reg  [`CCP_TXNID_W-1:0]    txreq_txnid,
	output reg  [`CCP_ADDR_W-1:0]     txreq_addr,
	output reg                        txreq_excl,
	output reg  [`CCP_NODEID_W-1:0]   txreq_srcid,
	output reg  [`CCP_NODEID_W-1:0]   txreq_tgtid,
	output reg  [`CCP_SRC_W-1:0]      txreq_logical_source_id,
	input  wire                       comp_valid,
	input  wire [`CCP_TXNID_W-1:0]    comp_txnid,
	input  wire                       dat_valid,
	input  wire                       dat_poison,
	output reg                        txdat_valid,
	output reg                        txdat_poison
);

// ----------------------------------------
// constants and helpers
// ----------------------------------------
localparam ST_IDLE  = 1'b0;
localparam ST_ISSUE = 1'b1;
localparam [15:0] CLUSTER_CAP = `CCP_SLICE_WBUF_COUNT * `CCP_SLICE_COUNT;
localparam [7:0] PORT_CAP = (CLUSTER_CAP < {8'h00, `CCP_MAX_OUTSTANDING}) ?
	CLUSTER_CAP[7:0] : `CCP_MAX_OUTSTANDING;

// writes and atomics count against the write budget, the rest read
function is_write_class;
	input [6:0] opc;
	begin
		is_write_class = (opc == `CCP_Q_WR_UNIQUE_ZERO) || (opc == `CCP_Q_WR_NOSNP_ZERO) ||
			(opc == `CCP_Q_WR_UNIQUE_PTL) || (opc[6:2] == `CCP_Q_ATOMIC_BASE >> 2);
	end
endfunction

// ----------------------------------------
// strap synchronisers
// ----------------------------------------
reg [4:0] strap_meta_q;
reg [4:0] strap_q;

// straps are pins, so two flops before use
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		strap_meta_q <= 5'h00;
		strap_q      <= 5'h00;
	end else if (ce) begin
		strap_meta_q <= {icache_inval_forward, tlb_inval_outer_forward, tlb_inval_inner_forward,
			persist_forward_strap, atomic_forward_strap};
		strap_q      <= strap_meta_q;
	end
end

wire atomic_ok  = strap_q[0];
wire persist_ok = strap_q[1];
wire tlbi_in_ok = strap_q[2];
wire tlbi_out_ok = strap_q[3];
wire icinv_ok   = strap_q[4];

// ----------------------------------------
// registers and apb slave
// ----------------------------------------
reg  [1:0]                ctrl_q;
reg  [`CCP_NODEID_W-1:0]  src_node_q;
reg  [`CCP_NODEID_W-1:0]  tgt_node_q;
reg  [7:0]                limit_q;
reg  [7:0]                rd_cnt_q;
reg  [7:0]                wr_cnt_q;
reg                       stray_q;
reg                       refuse_q;
reg                       state_q;
wire                      stray_set;
wire                      refuse_set;

wire apb_setup  = psel && !penable && !pready;
wire apb_write  = psel && penable && pready && pwrite;
wire addr_known = (paddr == `CCP_REG_CTRL) || (paddr == `CCP_REG_NODE) ||
	(paddr == `CCP_REG_LIMIT) || (paddr == `CCP_REG_STATUS);
wire [7:0] limit_wr = pwdata[7:0];

// read data and pready are staged in the setup cycle: one wait-free access
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		pready  <= 1'b0;
		pslverr <= 1'b0;
		prdata  <= 32'h00000000;
	end else if (ce) begin
		pready  <= apb_setup;
		pslverr <= apb_setup && !addr_known;
		if (apb_setup && !pwrite) begin
			if (paddr == `CCP_REG_CTRL)
				prdata <= {30'h00000000, ctrl_q};
			else if (paddr == `CCP_REG_NODE)
				prdata <= {5'h00, tgt_node_q, 5'h00, src_node_q};
			else if (paddr == `CCP_REG_LIMIT)
				prdata <= {24'h000000, limit_q};
			else if (paddr == `CCP_REG_STATUS)
				prdata <= {6'h00, refuse_q, stray_q, 3'h0, strap_q, wr_cnt_q, rd_cnt_q};
			else
				prdata <= 32'h00000000;
		end else begin
			prdata <= 32'h00000000;
		end
	end
end

// writable registers; sticky flags let a new event beat the clear
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		ctrl_q     <= `CCP_CTRL_RESET;
		src_node_q <= 11'h000;
		tgt_node_q <= 11'h000;
		limit_q    <= PORT_CAP;
		stray_q    <= 1'b0;
		refuse_q   <= 1'b0;
	end else if (ce) begin
		if (apb_write && paddr == `CCP_REG_CTRL)
			ctrl_q <= pwdata[1:0];
		if (apb_write && paddr == `CCP_REG_NODE) begin
			src_node_q <= pwdata[`CCP_NODE_SRC_LSB +: `CCP_NODEID_W];
			tgt_node_q <= pwdata[`CCP_NODE_TGT_LSB +: `CCP_NODEID_W];
		end
		// zero or oversized limits fall back to the port capacity
		if (apb_write && paddr == `CCP_REG_LIMIT)
			limit_q <= (limit_wr == 8'h00 || limit_wr > PORT_CAP) ? PORT_CAP : limit_wr;
		if (stray_set)
			stray_q <= 1'b1;
		else if (apb_write && paddr == `CCP_REG_STATUS && pwdata[`CCP_ST_STRAY_BIT])
			stray_q <= 1'b0;
		if (refuse_set)
			refuse_q <= 1'b1;
		else if (apb_write && paddr == `CCP_REG_STATUS && pwdata[`CCP_ST_REFUSE_BIT])
			refuse_q <= 1'b0;
	end
end

// ----------------------------------------
// operation to request mapping
// ----------------------------------------
reg [6:0] map_opc;
reg       map_allowed;
reg       map_excl;

// never emits plain persist clean nor the read-once deallocating reads
always @* begin
	map_opc     = `CCP_Q_NONE;
	map_allowed = 1'b1;
	map_excl    = 1'b0;
	case (op_kind)
		`CCP_OP_LOAD_FILL,
		`CCP_OP_FETCH_FILL: map_opc = `CCP_Q_READ_NSD;
		`CCP_OP_STORE_FILL: map_opc = `CCP_Q_READ_UNIQUE;
		`CCP_OP_STORE_SHARED: begin
			map_opc  = `CCP_Q_MAKE_READ_UNQ;
			map_excl = op_excl;
		end
		`CCP_OP_SPEC_STORE: map_opc = `CCP_Q_READ_PREF_UNQ;
		`CCP_OP_LOAD_EXCL: begin
			map_opc  = `CCP_Q_READ_PREF_UNQ;
			map_excl = 1'b1;
		end
		`CCP_OP_FULL_STORE: map_opc = `CCP_Q_MAKE_UNIQUE;
		`CCP_OP_ZERO_LINE: map_opc = op_shareable ? `CCP_Q_WR_UNIQUE_ZERO : `CCP_Q_WR_NOSNP_ZERO;
		`CCP_OP_ACP_PARTIAL: map_opc = `CCP_Q_WR_UNIQUE_PTL;
		`CCP_OP_ATOMIC: begin
			map_opc     = `CCP_Q_ATOMIC_BASE | {5'h00, op_aux};
			map_allowed = atomic_ok;
		end
		`CCP_OP_PERSIST_CLEAN: begin
			map_opc     = `CCP_Q_PERSIST_SEP;
			map_allowed = persist_ok;
		end
		`CCP_OP_TLB_INNER: begin
			map_opc     = `CCP_Q_DVM_OP;
			map_allowed = tlbi_in_ok;
		end
		`CCP_OP_TLB_OUTER: begin
			map_opc     = `CCP_Q_DVM_OP;
			map_allowed = tlbi_out_ok;
		end
		`CCP_OP_ICACHE_INVAL: begin
			map_opc     = `CCP_Q_DVM_OP;
			map_allowed = icinv_ok;
		end
		default: map_allowed = 1'b0;
	endcase
end

// ----------------------------------------
// id pool and outstanding tracking
// ----------------------------------------
reg [`CCP_ID_POOL-1:0]   id_busy_q;
reg [`CCP_ID_POOL-1:0]   id_write_q;
reg [`CCP_ID_POOL-1:0]   id_excl_q;
reg [`CCP_SRC_W-1:0]     id_src_q [0:`CCP_ID_POOL-1];
reg [`CCP_THREADS-1:0]   excl_busy_q;
reg [`CCP_ID_IDX_W-1:0]  free_idx;
reg                      free_any;
integer                  i;

// lowest free id; busy ids are skipped so none is reused
always @* begin
	free_idx = {`CCP_ID_IDX_W{1'b0}};
	free_any = 1'b0;
	for (i = `CCP_ID_POOL - 1; i >= 0; i = i - 1) begin
		if (!id_busy_q[i]) begin
			free_idx = i[`CCP_ID_IDX_W-1:0];
			free_any = 1'b1;
		end
	end
end

wire [`CCP_ID_IDX_W-1:0] comp_idx = comp_txnid[`CCP_ID_IDX_W-1:0];
wire comp_in_pool = (comp_txnid[`CCP_TXNID_W-1:`CCP_ID_IDX_W] == 5'h00);
wire comp_hit     = comp_valid && comp_in_pool && id_busy_q[comp_idx];
assign stray_set  = comp_valid && !comp_hit;

wire accept     = op_valid && op_ready;
wire excl_clash = map_excl && excl_busy_q[op_source_id];
wire refused    = accept && (!map_allowed || excl_clash);
wire take       = accept && !refused;
wire take_wr    = is_write_class(map_opc);
assign refuse_set = refused;

wire [8:0] total_cnt = {1'b0, rd_cnt_q} + {1'b0, wr_cnt_q};
// conservative room test: either class may come next
wire room = free_any && (rd_cnt_q < limit_q) && (wr_cnt_q < limit_q) &&
	(total_cnt < {1'b0, PORT_CAP});

wire rd_inc = take && !take_wr;
wire wr_inc = take && take_wr;
wire rd_dec = comp_hit && !id_write_q[comp_idx];
wire wr_dec = comp_hit && id_write_q[comp_idx];

// id reserved at acceptance; completion frees it and its exclusive slot
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		id_busy_q   <= {`CCP_ID_POOL{1'b0}};
		id_write_q  <= {`CCP_ID_POOL{1'b0}};
		id_excl_q   <= {`CCP_ID_POOL{1'b0}};
		excl_busy_q <= {`CCP_THREADS{1'b0}};
		rd_cnt_q    <= 8'h00;
		wr_cnt_q    <= 8'h00;
	end else if (ce) begin
		if (comp_hit) begin
			id_busy_q[comp_idx] <= 1'b0;
			if (id_excl_q[comp_idx])
				excl_busy_q[id_src_q[comp_idx]] <= 1'b0;
		end
		if (take) begin
			id_busy_q[free_idx]  <= 1'b1;
			id_write_q[free_idx] <= take_wr;
			id_excl_q[free_idx]  <= map_excl;
			if (map_excl)
				excl_busy_q[op_source_id] <= 1'b1;
		end
		rd_cnt_q <= rd_cnt_q + {7'h00, rd_inc} - {7'h00, rd_dec};
		wr_cnt_q <= wr_cnt_q + {7'h00, wr_inc} - {7'h00, wr_dec};
	end
end

// source of each id, only read while the id is busy
always @(posedge pclk) begin
	if (ce && take)
		id_src_q[free_idx] <= op_source_id;
end

// ----------------------------------------
// request issue
// ----------------------------------------
wire issue_done = (state_q == ST_ISSUE) && txreq_ready;
reg  state_d;

always @* begin
	state_d = state_q;
	case (state_q)
		ST_IDLE:  if (take) state_d = ST_ISSUE;
		ST_ISSUE: if (txreq_ready) state_d = ST_IDLE;
		default:  state_d = ST_IDLE;
	endcase
end

// one request in flight on the flit port; ready drops a cycle after each accept
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		state_q                 <= ST_IDLE;
		op_ready                <= 1'b0;
		op_done                 <= 1'b0;
		op_status               <= `CCP_STAT_ISSUED;
		txreq_valid             <= 1'b0;
		txreq_opcode            <= `CCP_Q_NONE;
		txreq_txnid             <= 12'h000;
		txreq_addr              <= 52'h0000000000000;
		txreq_excl              <= 1'b0;
		txreq_srcid             <= 11'h000;
		txreq_tgtid             <= 11'h000;
		txreq_logical_source_id <= 5'h00;
	end else if (ce) begin
		state_q  <= state_d;
		op_ready <= (state_d == ST_IDLE) && !accept && room && ctrl_q[`CCP_CTRL_EN_BIT];
		op_done  <= refused || issue_done;
		if (refused)
			op_status <= excl_clash ? `CCP_STAT_EXCL_BUSY : `CCP_STAT_NO_FEATURE;
		else if (issue_done)
			op_status <= `CCP_STAT_ISSUED;
		if (take) begin
			txreq_valid             <= 1'b1;
			txreq_opcode            <= map_opc;
			txreq_txnid             <= {5'h00, free_idx};
			txreq_addr              <= op_addr;
			txreq_excl              <= map_excl;
			txreq_srcid             <= src_node_q;
			txreq_tgtid             <= tgt_node_q;
			txreq_logical_source_id <= op_source_id;
		end else if (issue_done) begin
			txreq_valid <= 1'b0;
		end
	end
end

// ----------------------------------------
// data channel poison
// ----------------------------------------
// poison dropped unless protection exists and software turned it on
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		txdat_valid  <= 1'b0;
		txdat_poison <= 1'b0;
	end else if (ce) begin
		txdat_valid  <= dat_valid; // only the flag rides here, never data
		txdat_poison <= dat_valid && dat_poison && `CCP_ECC_PRESENT && ctrl_q[`CCP_CTRL_POISON_BIT];
	end
end

endmodule // ccp_periph_port

// file: rtl/ccp_defs.vh
`ifndef CCP_DEFS_VH
`define CCP_DEFS_VH
// ----------------------------------------
// build figures
// ----------------------------------------
`define CCP_MAX_OUTSTANDING   8'd128
`define CCP_SLICE_WBUF_COUNT  8'd16
`define CCP_SLICE_COUNT       8'd4
`define CCP_ECC_PRESENT       1'b1
`define CCP_ID_POOL           128
`define CCP_ID_IDX_W          7
`define CCP_TXNID_W           12
`define CCP_NODEID_W          11
`define CCP_ADDR_W            52
`define CCP_SRC_W             5
`define CCP_THREADS           32
// ----------------------------------------
// register byte offsets and fields
// ----------------------------------------
`define CCP_REG_CTRL          12'h000
`define CCP_REG_NODE          12'h004
`define CCP_REG_LIMIT         12'h008
`define CCP_REG_STATUS        12'h00C
`define CCP_CTRL_EN_BIT       0
`define CCP_CTRL_POISON_BIT   1
`define CCP_NODE_SRC_LSB      0
`define CCP_NODE_TGT_LSB      16
`define CCP_ST_RD_LSB         0
`define CCP_ST_WR_LSB         8
`define CCP_ST_STRAP_LSB      16
`define CCP_ST_STRAY_BIT      24
`define CCP_ST_REFUSE_BIT     25
`define CCP_CTRL_RESET        2'h0
// ----------------------------------------
// cluster operation kinds
// ----------------------------------------
`define CCP_OP_LOAD_FILL      4'h0
`define CCP_OP_FETCH_FILL     4'h1
`define CCP_OP_STORE_FILL     4'h2
`define CCP_OP_STORE_SHARED   4'h3
`define CCP_OP_SPEC_STORE     4'h4
`define CCP_OP_LOAD_EXCL      4'h5
`define CCP_OP_FULL_STORE     4'h6
`define CCP_OP_ZERO_LINE      4'h7
`define CCP_OP_ACP_PARTIAL    4'h8
`define CCP_OP_ATOMIC         4'h9
`define CCP_OP_PERSIST_CLEAN  4'hA
`define CCP_OP_TLB_INNER      4'hB
`define CCP_OP_TLB_OUTER      4'hC
`define CCP_OP_ICACHE_INVAL   4'hD
// ----------------------------------------
// request opcodes, local encoding
// ----------------------------------------
`define CCP_Q_NONE            7'h00
`define CCP_Q_READ_NSD        7'h01
`define CCP_Q_READ_UNIQUE     7'h02
`define CCP_Q_MAKE_READ_UNQ   7'h03
`define CCP_Q_READ_PREF_UNQ   7'h04
`define CCP_Q_MAKE_UNIQUE     7'h05
`define CCP_Q_WR_UNIQUE_ZERO  7'h06
`define CCP_Q_WR_NOSNP_ZERO   7'h07
`define CCP_Q_WR_UNIQUE_PTL   7'h08
`define CCP_Q_ATOMIC_BASE     7'h10
`define CCP_Q_PERSIST_SEP     7'h14
`define CCP_Q_DVM_OP          7'h15
// ----------------------------------------
// operation status codes
// ----------------------------------------
`define CCP_STAT_ISSUED       2'h0
`define CCP_STAT_NO_FEATURE   2'h1
`define CCP_STAT_EXCL_BUSY    2'h2
`endif

// file: testbench/ccp_periph_port_assertions.sv
`timescale 1ns/1ns
`include "ccp_defs.vh"
module ccp_chk (
	input wire        pclk,
	input wire        presetn,
	input wire        op_valid,
	input wire        op_ready,
	input wire [3:0]  op_kind,
	input wire        op_excl,
	input wire [51:0] op_addr,
	input wire [4:0]  op_source_id,
	input wire        op_done,
	input wire [1:0]  op_status,
	input wire        atomic_forward_strap,
	input wire        persist_forward_strap,
	input wire        tlb_inval_inner_forward,
	input wire        tlb_inval_outer_forward,
	input wire        icache_inval_forward,
	input wire        txreq_valid,
	input wire        txreq_ready,
	input wire [6:0]  txreq_opcode,
	input wire [11:0] txreq_txnid,
	input wire [51:0] txreq_addr,
	input wire        txreq_excl,
	input wire [4:0]  txreq_logical_source_id,
	input wire        dat_valid,
	input wire        dat_poison,
	input wire        txdat_valid,
	input wire        txdat_poison
);
	// ----------------------------------------
	// request and data side properties
	// ----------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire take = op_valid && op_ready;
	property p_hold; txreq_valid && !txreq_ready |=> txreq_valid && $stable(txreq_opcode) && $stable(txreq_txnid); endproperty
	a_hold: assert property (p_hold) else $error("request changed before handshake");
	property p_id; txreq_valid |-> txreq_txnid < 12'd128; endproperty
	a_id: assert property (p_id) else $error("id outside pool");
	property p_src; take && op_kind < 4'h3 |=> txreq_valid && txreq_logical_source_id == $past(op_source_id)
		&& txreq_addr == $past(op_addr); endproperty
	a_src: assert property (p_src) else $error("source or address lost");
	property p_fill; take && op_kind < 4'h3 |=> txreq_opcode == ($past(op_kind) == 4'h2 ? 7'h02 : 7'h01); endproperty
	a_fill: assert property (p_fill) else $error("wrong linefill opcode");
	property p_mru; take && op_kind == 4'h3 |=> op_done || (txreq_opcode == 7'h03 && txreq_excl == $past(op_excl)); endproperty
	a_mru: assert property (p_mru) else $error("wrong shared store request");
	property p_atom; txreq_valid && txreq_opcode[6:2] == 5'h04 |-> atomic_forward_strap; endproperty
	a_atom: assert property (p_atom) else $error("atomic with strap low");
	property p_pers; txreq_valid && txreq_opcode == 7'h14 |-> persist_forward_strap; endproperty
	a_pers: assert property (p_pers) else $error("persist with strap low");
	property p_dvm; txreq_valid && txreq_opcode == 7'h15 |->
		tlb_inval_inner_forward || tlb_inval_outer_forward || icache_inval_forward; endproperty
	a_dvm: assert property (p_dvm) else $error("maintenance with straps low");
	property p_pois; txdat_poison |-> $past(dat_valid && dat_poison); endproperty
	a_pois: assert property (p_pois) else $error("poison without cause");
	property p_done; txreq_valid && txreq_ready |=> op_done && op_status == 2'h0; endproperty
	a_done: assert property (p_done) else $error("no issued status");
	c_atom: cover property (txreq_valid && txreq_ready && txreq_opcode[6:2] == 5'h04);
	c_excl: cover property (op_done && op_status == 2'h2);
	c_slow: cover property (txreq_valid && !txreq_ready ##1 txreq_valid && !txreq_ready);
endmodule // ccp_chk
bind ccp_periph_port ccp_chk ccp_chk_i (.*);

// file: testbench/ccp_icn_model.sv
`timescale 1ns/1ns
module ccp_icn_model (
	input wire        pclk,
	input wire        presetn,
	input wire        txreq_valid,
	input wire [11:0] txreq_txnid,
	input wire [1:0]  slow,
	input wire        hold,
	input wire        stray,
	output reg        txreq_ready,
	output reg        comp_valid,
	output reg [11:0] comp_txnid,
	output reg [31:0] dup_errors
);
	reg [127:0] busy_q;
	reg [1:0]   wait_q;
	integer     i;
	integer     pick;
	// credits, then completions lowest id first; hold stalls them
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			txreq_ready <= 1'b0;
			comp_valid <= 1'b0;
			comp_txnid <= 12'h000;
			busy_q <= 128'h0;
			wait_q <= 2'h0;
			dup_errors <= 32'h0;
		end else begin
			pick = -1;
			for (i = 127; i >= 0; i = i - 1)
				if (busy_q[i])
					pick = i;
			comp_valid <= 1'b0;
			comp_txnid <= ~comp_txnid; // no stale id between completions
			if (txreq_valid && txreq_ready) begin
				if (busy_q[txreq_txnid[6:0]])
					dup_errors <= dup_errors + 32'h1;
				busy_q[txreq_txnid[6:0]] <= 1'b1;
				wait_q <= 2'h0;
			end else if (txreq_valid)
				wait_q <= wait_q + 2'h1;
			txreq_ready <= txreq_valid && !txreq_ready && wait_q >= slow;
			if (stray) begin
				comp_valid <= 1'b1;
				comp_txnid <= 12'hFFF;
			end else if (!hold && !comp_valid && pick >= 0) begin
				comp_valid <= 1'b1;
				comp_txnid <= pick[11:0];
				busy_q[pick] <= 1'b0;
			end
		end
	end
endmodule // ccp_icn_model

// file: testbench/test_ccp_periph_port.sv
`timescale 1ns/1ns
`include "ccp_defs.vh"
module test_ccp_periph_port;
	reg pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0, op_valid = 0, op_shareable = 0;
	reg op_excl = 0, dat_valid = 0, dat_poison = 0, hold = 0, stray = 0, atomic_forward_strap = 0;
	reg persist_forward_strap = 0, tlb_inval_inner_forward = 0, tlb_inval_outer_forward = 0, icache_inval_forward = 0;
	reg [11:0] paddr = 0;
	reg [31:0] pwdata = 0, rd;
	reg [3:0] op_kind = 0;
	reg [1:0] op_aux = 0, slow = 0, st;
	reg [51:0] op_addr = 0;
	reg [4:0] op_source_id = 0, g_lp;
	reg er, tk, got, g_ex;
	reg [6:0] g_op;
	reg [11:0] g_id;
	reg [10:0] g_src, g_tgt;
	reg [51:0] g_ad;
	wire [31:0] prdata, dup_errors;
	wire pready, pslverr, op_ready, op_done, txreq_valid, txreq_ready, txreq_excl, comp_valid, txdat_valid, txdat_poison;
	wire [1:0] op_status;
	wire [6:0] txreq_opcode;
	wire [11:0] txreq_txnid, comp_txnid;
	wire [51:0] txreq_addr;
	wire [10:0] txreq_srcid, txreq_tgtid;
	wire [4:0] txreq_logical_source_id;
	integer failures = 0, checked = 0, i;
	// kind, shareable, excl in, excl out, opcode
	localparam [13:0] TBL [0:10] = '{14'h0001, 14'h0401, 14'h0802, 14'h0C03, 14'h0D83, 14'h1004,
		14'h1484, 14'h1805, 14'h1E06, 14'h1C07, 14'h2008};
	ccp_periph_port ccp_periph_port_i (.*);
	ccp_icn_model ccp_icn_model_i (.*);
	always #50 pclk = ~pclk;
	// capture each request at its handshake edge
	always @(posedge pclk) begin
		if (txreq_valid === 1'b1 && txreq_ready === 1'b1) begin
			got = 1;
			g_op = txreq_opcode;
			g_id = txreq_txnid;
			g_ex = txreq_excl;
			g_src = txreq_srcid;
			g_tgt = txreq_tgtid;
			g_lp = txreq_logical_source_id;
			g_ad = txreq_addr;
		end
	end
	// wide enough that error flag and read word are compared together
	task check(input [63:0] seen, input [63:0] exp);
		begin
			checked = checked + 1;
			if (seen !== exp) begin
				failures = failures + 1;
				$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
			end
		end
	endtask
	task end_of_test;
		begin
			$display("comparisons %0d mismatches %0d", checked, failures);
			if (failures == 0 && checked > 0)
				$display("Testbench passed");
			else
				$display("Testbench failed");
			$finish;
		end
	endtask
	// one apb transfer, then an idle edge so calls never collide
	// no cycle limit on pready: a hung slave is left to the watchdog
	task apb(input w, input [11:0] a, input [31:0] d);
		begin
			psel <= 1;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge pclk);
			penable <= 1;
			do @(posedge pclk); while (pready !== 1'b1);
			rd = prdata;
			er = pslverr;
			psel <= 0;
			penable <= 0;
			@(posedge pclk);
		end
	endtask
	// offer one operation; tk tells whether it was taken at all
	task op(input [3:0] k, input [1:0] ax, input sh, input ex, input [4:0] src);
		integer n;
		begin
			got = 0;
			st = 2'h3;
			op_valid <= 1;
			op_kind <= k;
			op_aux <= ax;
			op_shareable <= sh;
			op_excl <= ex;
			op_source_id <= src;
			op_addr <= {src, 47'h0ABC_DEF0_1240};
			n = 0;
			do begin @(posedge pclk); n = n + 1; end while (op_ready !== 1'b1 && n < 20);
			tk = (op_ready === 1'b1);
			op_valid <= 0;
			n = 0;
			if (tk)
				do begin @(posedge pclk); n = n + 1; end while (op_done !== 1'b1 && n < 20);
			if (tk)
				st = op_status;
			@(posedge pclk);
		end
	endtask
	initial begin
		#5000000;
		failures = failures + 1;
		end_of_test;
	end
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1;
		repeat (2) @(posedge pclk);
		apb(0, `CCP_REG_CTRL, 0);
		check(rd, 0);
		apb(0, `CCP_REG_LIMIT, 0);
		check(rd, 64);
		apb(0, 12'h010, 0);
		check({er, rd}, 33'h100000000);
		apb(1, `CCP_REG_LIMIT, 32'hFF);
		apb(0, `CCP_REG_LIMIT, 0);
		check(rd, 64);
		$display("test registers done");
		apb(1, `CCP_REG_CTRL, 3);
		apb(1, `CCP_REG_NODE, 32'h02AB0155);
		for (i = 0; i < 11; i = i + 1) begin
			slow <= i[1:0];
			op(TBL[i][13:10], 0, TBL[i][9], TBL[i][8], i[4:0]);
			check({st, got, g_ex, g_op}, {2'h0, 1'b1, TBL[i][7:0]});
			check({g_src, g_tgt, g_lp}, {11'h155, 11'h2AB, i[4:0]});
			check(g_ad, {i[4:0], 47'h0ABC_DEF0_1240});
		end
		for (i = 9; i < 15; i = i + 1) begin
			op(i[3:0], 0, 0, 0, 0);
			check({st, got}, 3'b010);
		end
		{atomic_forward_strap, persist_forward_strap, tlb_inval_inner_forward} <= 3'b111;
		{tlb_inval_outer_forward, icache_inval_forward} <= 2'b11;
		repeat (3) @(posedge pclk);
		for (i = 0; i < 8; i = i + 1) begin
			op(i < 4 ? 9 : i + 6, i[1:0], 0, 0, 0);
			check({st, g_op}, {2'h0, i < 4 ? 7'h10 + i[6:0] : (i == 4 ? 7'h14 : 7'h15)});
		end
		$display("test request mapping done");
		repeat (20) @(posedge pclk);
		hold <= 1;
		op(5, 0, 0, 0, 7);
		check({st, g_ex}, 3'b001);
		op(5, 0, 0, 0, 7);
		check(st, 2);
		op(3, 0, 0, 1, 7);
		check(st, 2);
		op(5, 0, 0, 0, 8);
		check(st, 0);
		hold <= 0;
		repeat (20) @(posedge pclk);
		op(5, 0, 0, 0, 7);
		check(st, 0);
		$display("test exclusive done");
		repeat (20) @(posedge pclk);
		hold <= 1;
		for (i = 0; i < 64; i = i + 1) begin
			op(0, 0, 0, 0, i[4:0]);
			check({tk, g_id}, {1'b1, i[11:0]});
		end
		op(0, 0, 0, 0, 0);
		check(tk, 0);
		apb(0, `CCP_REG_STATUS, 0);
		check(rd[15:0], 16'h0040);
		hold <= 0;
		repeat (300) @(posedge pclk);
		stray <= 1;
		@(posedge pclk);
		stray <= 0;
		repeat (3) @(posedge pclk);
		apb(0, `CCP_REG_STATUS, 0);
		check(rd, 32'h031F0000);
		apb(1, `CCP_REG_STATUS, 32'h03000000);
		apb(0, `CCP_REG_STATUS, 0);
		check(rd, 32'h001F0000);
		$display("test capacity done");
		for (i = 0; i < 2; i = i + 1) begin
			apb(1, `CCP_REG_CTRL, 3 - 2 * i);
			dat_valid <= 1;
			dat_poison <= 1;
			@(posedge pclk);
			dat_valid <= 0;
			dat_poison <= 0;
			@(posedge pclk);
			check({txdat_valid, txdat_poison}, {1'b1, i == 0});
		end
		check(dup_errors, 0);
		$display("test poison done");
		end_of_test;
	end
endmodule // test_ccp_periph_port
